// ===== logic/sdm_drive.sv
// Purpose: Drive end: step/direction intake, fault latch, blink code
// Assumes: Link pins asynchronous to mclk; fault inputs are comparator levels
// Notes:   Faults clear only by rst_n (power-up)
`timescale 1ns/1ns
// Operation
// - Permit settles 5 us before direction
// - Direction steady 5 us before step
// - Step high phase at least 2.5 us
// - Step low phase at least 2.5 us
// - Over-current fault, first priority, one blink
// - Over-voltage fault, second priority, two blinks
// - Fault de-energises phases and blinks LED
// - Faults latch until power-up reset
// - Disabled drive ignores step pulses
// - Standstill halves current after one second
module sdm_drive #(
  parameter int IDLE_CYC  = sdm_pkg::IDLE_CYC,
  parameter int ON_CYC    = sdm_pkg::BLINK_ON_CYC,
  parameter int OFF_CYC   = sdm_pkg::BLINK_OFF_CYC,
  parameter int GAP_CYC   = sdm_pkg::BLINK_GAP_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Sensors and switches
  input  wire logic        over_current,
  input  wire logic        over_voltage,
  input  wire logic        standstill_select,
  // Link
  sdm_if.drive             lnk,
  // Outputs
  output logic             phase_enable_ff,
  output logic             half_current_ff,
  output logic             red_led_ff,
  output logic [15:0]      position_ff,
  output logic             timing_error_ff,
  output logic             oc_fault_ff,
  output logic             ov_fault_ff
);
  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Every pin crosses two flops; only the second stage is ever read
  localparam int NSYNC = 6;
  wire  [NSYNC-1:0] pin_raw = {standstill_select, over_voltage, over_current,
                               lnk.output_permit, lnk.motion_sense, lnk.step_strobe};
  wire  [NSYNC-1:0] pin_s;
  for (genvar gi = 0; gi < NSYNC; gi++) begin : g_sync
    logic s1_ff;
    logic s2_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
      end else if (ce) begin
        s1_ff <= pin_raw[gi];
        s2_ff <= s1_ff;
      end
    end
    assign pin_s[gi] = s2_ff;
  end
  wire  stp_s  = pin_s[0];
  wire  dir_s  = pin_s[1];
  wire  en_s   = pin_s[2];
  wire  oc_s   = pin_s[3];
  wire  ov_s   = pin_s[4];
  wire  hold_s = pin_s[5];
  logic stp_d_ff, dir_d_ff, en_d_ff;
  wire  rise   = stp_s && !stp_d_ff;
  wire  fall   = !stp_s && stp_d_ff;
  wire  fault  = oc_fault_ff || ov_fault_ff;
  // ----------------------------------------------------------------
  // Timing checks on the controller side
  // ----------------------------------------------------------------
  // Age counters saturate so a long idle never wraps into a false short.
  // Both ends of a gap pass the same flops, so a legal gap of N cycles
  // shows here as an age of N - 1 when the second edge is seen.
  localparam int NAGE = 3;
  wire [NAGE-1:0]       age_clr = {rise || fall, dir_s != dir_d_ff, en_s != en_d_ff};
  wire [NAGE-1:0][15:0] age_w;
  for (genvar ga = 0; ga < NAGE; ga++) begin : g_age
    logic [15:0] age_ff;
    wire         age_top = age_ff == 16'hFFFF;
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        age_ff <= 16'hFFFF;
      end else if (ce) begin
        if (age_clr[ga]) begin
          age_ff <= 16'h0000;
        end else if (!age_top) begin
          age_ff <= age_ff + 16'h0001;
        end
      end
    end
    assign age_w[ga] = age_ff;
  end
  wire [15:0] en_age       = age_w[0];
  wire [15:0] dir_age      = age_w[1];
  wire [15:0] lvl_age      = age_w[2];
  wire        dir_bad      = rise && dir_age < 16'(sdm_pkg::DIR_STEP_CYC - 1);
  wire        hi_bad       = fall && lvl_age < 16'(sdm_pkg::HIGH_CYC - 1);
  wire        lo_bad       = rise && lvl_age < 16'(sdm_pkg::LOW_CYC - 1);
  wire        en_bad       = age_clr[1] && en_age < 16'(sdm_pkg::EN_DIR_CYC - 1);
  wire        step_ok      = rise && en_s && !fault;
  wire [15:0] nxt_position = dir_s ? position_ff + 16'h0001 : position_ff - 16'h0001;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stp_d_ff <= 1'b0;
      dir_d_ff <= 1'b0;
      en_d_ff <= 1'b0;
      timing_error_ff <= 1'b0;
      position_ff <= sdm_pkg::POS_RST;
    end else if (ce) begin
      stp_d_ff <= stp_s;
      dir_d_ff <= dir_s;
      en_d_ff <= en_s;
      timing_error_ff <= dir_bad || hi_bad || lo_bad || en_bad;
      if (step_ok) begin
        position_ff <= nxt_position;
      end
    end
  end
  // ----------------------------------------------------------------
  // Fault latch
  // ----------------------------------------------------------------
  // Set wins over everything; only rst_n clears a latched fault
  wire nxt_phase_enable = en_s && !fault && !oc_s && !ov_s;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oc_fault_ff <= 1'b0;
      ov_fault_ff <= 1'b0;
      phase_enable_ff <= 1'b0;
    end else if (ce) begin
      if (oc_s) oc_fault_ff <= 1'b1;
      if (ov_s) ov_fault_ff <= 1'b1;
      phase_enable_ff <= nxt_phase_enable;
    end
  end
  // ----------------------------------------------------------------
  // Standstill reduction
  // ----------------------------------------------------------------
  // The idle count stops at its end value so it never wraps to full current
  logic [31:0] idle_ff;
  wire         idle_done = idle_ff == 32'(IDLE_CYC);
  wire         nxt_half  = !hold_s && !step_ok && idle_done;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idle_ff <= 32'h00000000;
      half_current_ff <= 1'b0;
    end else if (ce) begin
      if (step_ok) begin
        idle_ff <= 32'h00000000;
      end else if (!idle_done) begin
        idle_ff <= idle_ff + 32'h00000001;
      end
      half_current_ff <= nxt_half;
    end
  end
  // ----------------------------------------------------------------
  // Blink code
  // ----------------------------------------------------------------
  // Code chosen at group start so a new fault never cuts a group short
  sdm_pkg::sdm_blink_t bst_ff;
  logic [31:0] bcnt_ff;
  logic [1:0]  left_ff;
  wire [1:0] code = oc_fault_ff ? sdm_pkg::OC_BLINKS : sdm_pkg::OV_BLINKS;
  wire       on_end  = bcnt_ff == 32'(ON_CYC - 1);
  wire       off_end = bcnt_ff == 32'(OFF_CYC - 1);
  wire       gap_end = bcnt_ff == 32'(GAP_CYC - 1);
  wire       last_on = left_ff == 2'h1;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bst_ff <= sdm_pkg::SDM_IDLE;
      bcnt_ff <= 32'h00000000;
      left_ff <= 2'h0;
      red_led_ff <= 1'b0;
    end else if (ce) begin
      bcnt_ff <= bcnt_ff + 32'h00000001;
      unique case (bst_ff)
        sdm_pkg::SDM_IDLE: begin
          if (fault) begin
            bst_ff <= sdm_pkg::SDM_ON;
            left_ff <= code;
            red_led_ff <= 1'b1;
            bcnt_ff <= 32'h00000000;
          end
        end
        sdm_pkg::SDM_ON: begin
          if (on_end) begin
            red_led_ff <= 1'b0;
            bcnt_ff <= 32'h00000000;
            left_ff <= left_ff - 2'h1;
            bst_ff <= last_on ? sdm_pkg::SDM_GAP : sdm_pkg::SDM_OFF;
          end
        end
        sdm_pkg::SDM_OFF: begin
          if (off_end) begin
            red_led_ff <= 1'b1;
            bcnt_ff <= 32'h00000000;
            bst_ff <= sdm_pkg::SDM_ON;
          end
        end
        sdm_pkg::SDM_GAP: begin
          if (gap_end) begin
            bst_ff <= sdm_pkg::SDM_IDLE;
          end
        end
      endcase
    end
  end
endmodule // sdm_drive

// ===== inc/sdm_pkg.sv
// Purpose: Shared constants for the step/direction fault monitor ends
// Assumes: 100 MHz clock
// Notes:   Times in ns (idle in ms); link counts derived by expression, blink counts given as cycles
package sdm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS          = 10;
  localparam int T_EN_DIR_NS     = 5000;
  localparam int T_DIR_STEP_NS   = 5000;
  localparam int T_HIGH_NS       = 2500;
  localparam int T_LOW_NS        = 2500;
  localparam int T_IDLE_MS       = 1000;
  localparam int EN_DIR_CYC      = (T_EN_DIR_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIR_STEP_CYC    = (T_DIR_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIGH_CYC        = (T_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOW_CYC         = (T_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int IDLE_CYC        = T_IDLE_MS * (1000000 / CLK_NS);
  // ----------------------------------------------------------------
  // Blink code
  // ----------------------------------------------------------------
  localparam int BLINK_ON_CYC    = 30000000;
  localparam int BLINK_OFF_CYC   = 30000000;
  localparam int BLINK_GAP_CYC   = 150000000;
  localparam logic [1:0] OC_BLINKS = 2'h1;
  localparam logic [1:0] OV_BLINKS = 2'h2;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] POS_RST = 16'h0000;
  typedef enum logic [1:0] {
    SDM_IDLE = 2'b00,
    SDM_ON   = 2'b01,
    SDM_OFF  = 2'b10,
    SDM_GAP  = 2'b11
  } sdm_blink_t;
  typedef enum logic [1:0] {
    SDM_H_IDLE = 2'b00,
    SDM_H_DIR  = 2'b01,
    SDM_H_HIGH = 2'b10,
    SDM_H_LOW  = 2'b11
  } sdm_host_t;
endpackage

// ===== inc/sdm_if.sv
// Purpose: Link between motion controller and drive logic
// Assumes: One clock, pins driven push-pull
// Notes:   No clocking block
`timescale 1ns/1ns
interface sdm_if;
  logic output_permit;
  logic motion_sense;
  logic step_strobe;
  modport drive (input output_permit, input motion_sense, input step_strobe);
  modport ctrl  (output output_permit, output motion_sense, output step_strobe);
endinterface

// ===== logic/sdm_ctrl.sv
// Purpose: Motion controller end, issues enable, direction and steps
// Assumes: Same clock as drive; requests taken when idle
// Notes:   Keeps all setup and width times toward the drive
`timescale 1ns/1ns
module sdm_ctrl (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  // User side
  input  wire logic enable_in,
  input  wire logic step_req,
  input  wire logic step_dir,
  output logic      busy_ff,
  // Link
  sdm_if.ctrl       lnk
);
  sdm_pkg::sdm_host_t st_ff;
  logic [15:0] cnt_ff;
  logic        en_ff, dir_ff, stp_ff;
  logic [15:0] en_age_ff;
  wire  en_ok = en_age_ff >= 16'(sdm_pkg::EN_DIR_CYC);
  wire  dir_chg = dir_ff != step_dir;
  // A permit change and a step in one cycle would break the permit lead
  wire  en_chg  = en_ff != enable_in;

  assign lnk.output_permit = en_ff;
  assign lnk.motion_sense  = dir_ff;
  assign lnk.step_strobe   = stp_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= sdm_pkg::SDM_H_IDLE;
      cnt_ff <= 16'h0000;
      en_ff <= 1'b0;
      dir_ff <= 1'b0;
      stp_ff <= 1'b0;
      busy_ff <= 1'b0;
      en_age_ff <= 16'h0000;
    end else if (ce) begin
      if (en_chg && st_ff == sdm_pkg::SDM_H_IDLE) begin
        en_ff <= enable_in;
        en_age_ff <= 16'h0000;
      end else if (!en_ok) begin
        en_age_ff <= en_age_ff + 16'h0001;
      end
      unique case (st_ff)
        sdm_pkg::SDM_H_IDLE: begin
          busy_ff <= 1'b0;
          if (step_req && en_ok && !en_chg) begin
            busy_ff <= 1'b1;
            dir_ff <= step_dir;
            cnt_ff <= 16'h0000;
            st_ff <= dir_chg ? sdm_pkg::SDM_H_DIR : sdm_pkg::SDM_H_HIGH;
            stp_ff <= !dir_chg;
          end
        end
        sdm_pkg::SDM_H_DIR: begin
          cnt_ff <= cnt_ff + 16'h0001;
          if (cnt_ff == 16'(sdm_pkg::DIR_STEP_CYC - 1)) begin
            stp_ff <= 1'b1;
            cnt_ff <= 16'h0000;
            st_ff <= sdm_pkg::SDM_H_HIGH;
          end
        end
        sdm_pkg::SDM_H_HIGH: begin
          cnt_ff <= cnt_ff + 16'h0001;
          if (cnt_ff == 16'(sdm_pkg::HIGH_CYC - 1)) begin
            stp_ff <= 1'b0;
            cnt_ff <= 16'h0000;
            st_ff <= sdm_pkg::SDM_H_LOW;
          end
        end
        sdm_pkg::SDM_H_LOW: begin
          cnt_ff <= cnt_ff + 16'h0001;
          if (cnt_ff == 16'(sdm_pkg::LOW_CYC - 1)) begin
            st_ff <= sdm_pkg::SDM_H_IDLE;
          end
        end
      endcase
    end
  end
endmodule // sdm_ctrl

// ===== test/sdm_assertions.sv
// Purpose: Link timing checks between controller and drive
// Assumes: 100 MHz clock, counts in cycles
// Notes:   Sees the interface signals only
`timescale 1ns/1ns
module sdm_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link
  input wire logic output_permit,
  input wire logic motion_sense,
  input wire logic step_strobe
);
  // ------
  // Ages since each edge
  // ------
  localparam int AGE = 499;
  localparam int WID = 249;
  logic        pe_ff, pd_ff, ps_ff;
  int unsigned ea_ff, da_ff, hc_ff, lc_ff;
  wire         rise = step_strobe & ~ps_ff;
  wire         fall = ~step_strobe & ps_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {pe_ff, pd_ff, ps_ff} <= 3'h0;
      {ea_ff, da_ff, hc_ff, lc_ff} <= '0;
    end else begin
      {pe_ff, pd_ff, ps_ff} <= {output_permit, motion_sense, step_strobe};
      ea_ff <= (output_permit != pe_ff) ? '0 : ea_ff + 1;
      da_ff <= (motion_sense != pd_ff) ? '0 : da_ff + 1;
      hc_ff <= rise ? '0 : hc_ff + 1;
      lc_ff <= fall ? '0 : lc_ff + 1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_rise;
    rise;
  endsequence
  property p_en_dir;
    (motion_sense != pd_ff) |-> ea_ff >= AGE;
  endproperty
  a_en_dir: assert property (p_en_dir) else $error("direction moved too soon after permit");
  property p_dir_step;
    s_rise |-> (da_ff >= AGE) && (motion_sense == pd_ff);
  endproperty
  a_dir_step: assert property (p_dir_step) else $error("step too soon after direction");
  property p_high;
    fall |-> hc_ff >= WID;
  endproperty
  a_high: assert property (p_high) else $error("step high phase short");
  property p_hold;
    s_rise |=> step_strobe [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("step pulse collapsed");
  property p_low;
    s_rise |-> lc_ff >= WID;
  endproperty
  a_low: assert property (p_low) else $error("step low phase short");
  sequence s_fall;
    fall;
  endsequence
  property p_low_hold;
    s_fall |=> !step_strobe [*8];
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("step low phase collapsed");
endmodule // sdm_assertions

// ===== test/step_dir_input_fault_monitor_bench.sv
// Purpose: Self-checking bench, controller facing drive
// Assumes: Shortened idle and blink counts
// Notes:   Blink counts taken over one group window
`timescale 1ns/1ns
module step_dir_input_fault_monitor_bench;
  // ------
  // Signals
  // ------
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        enable_in = 1'b0;
  logic        step_req = 1'b0;
  logic        step_dir = 1'b1;
  logic        over_current = 1'b0;
  logic        over_voltage = 1'b0;
  logic        standstill_select = 1'b0;
  logic        ce = 1'b1;
  logic        timing_error_ff;
  int          te_count = 0;
  logic        busy_ff, phase_enable_ff, half_current_ff, red_led_ff, oc_fault_ff, ov_fault_ff;
  logic [15:0] position_ff;
  int          bad_count = 0;
  int          checks_done = 0;
  int          n;
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (timing_error_ff === 1'b1) te_count++;
  sdm_if sdm_if_inst ();
  sdm_ctrl sdm_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce), .enable_in(enable_in),
    .step_req(step_req), .step_dir(step_dir), .busy_ff(busy_ff), .lnk(sdm_if_inst.ctrl));
  sdm_drive #(.IDLE_CYC(1000), .ON_CYC(20), .OFF_CYC(20), .GAP_CYC(100)) sdm_drive_inst (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .over_current(over_current),
    .over_voltage(over_voltage), .standstill_select(standstill_select), .lnk(sdm_if_inst.drive),
    .phase_enable_ff(phase_enable_ff), .half_current_ff(half_current_ff), .red_led_ff(red_led_ff),
    .position_ff(position_ff), .timing_error_ff(timing_error_ff), .oc_fault_ff(oc_fault_ff),
    .ov_fault_ff(ov_fault_ff));
  sdm_assertions sdm_assertions_inst (.mclk(mclk), .rst_n(rst_n),
    .output_permit(sdm_if_inst.output_permit), .motion_sense(sdm_if_inst.motion_sense),
    .step_strobe(sdm_if_inst.step_strobe));
  // ------
  // Tasks
  // ------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic step(input logic dir);
    int i;
    step_req <= 1'b1;
    step_dir <= dir;
    @(posedge mclk);
    step_req <= 1'b0;
    for (i = 0; i < 5 && busy_ff !== 1'b1; i++) @(posedge mclk);
    if (busy_ff !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
    for (i = 0; i < 2000 && busy_ff !== 1'b0; i++) @(posedge mclk);
    if (i == 2000) begin
      bad_count++;
      tally_and_finish();
    end
    cyc(8);
  endtask
  // Waits for a pause longer than any off phase, then counts one group
  task automatic blinks(output int cnt);
    int   i, lo;
    logic p;
    lo = 0;
    cnt = 0;
    p = 1'b0;
    for (i = 0; i < 2000 && lo < 40; i++) begin
      @(posedge mclk);
      lo = red_led_ff ? 0 : lo + 1;
    end
    // Window opens at the group's first blink and closes before the next group
    for (i = 0; i < 200 && cnt == 0; i++) begin
      @(posedge mclk);
      if (red_led_ff && !p) cnt++;
      p = red_led_ff;
    end
    if (lo < 40 || cnt == 0) begin
      bad_count++;
      tally_and_finish();
    end
    repeat (100) begin
      @(posedge mclk);
      if (red_led_ff && !p) cnt++;
      p = red_led_ff;
    end
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    cyc(2);
    rst_n <= 1'b1;
    cyc(2);
    chk(position_ff, 16'h0000);
    enable_in <= 1'b1;
    cyc(600);
    step(1'b1);
    chk(position_ff, 16'h0001);
    step(1'b1);
    chk(position_ff, 16'h0002);
    step(1'b0);
    chk(position_ff, 16'h0001);
    step(1'b0);
    step(1'b0);
    chk(position_ff, 16'hFFFF);
    cyc(1100);
    chk({15'h0, half_current_ff}, 16'h0001);
    step(1'b1);
    chk({15'h0, half_current_ff}, 16'h0000);
    standstill_select <= 1'b1;
    cyc(1100);
    chk({15'h0, half_current_ff}, 16'h0000);
    ce <= 1'b0;
    over_voltage <= 1'b1;
    cyc(6);
    chk({13'h0, oc_fault_ff, ov_fault_ff, phase_enable_ff}, 16'h0001);
    ce <= 1'b1;
    cyc(6);
    chk({13'h0, oc_fault_ff, ov_fault_ff, phase_enable_ff}, 16'h0002);
    blinks(n);
    chk(16'(n), 16'h0002);
    over_current <= 1'b1;
    cyc(6);
    blinks(n);
    chk(16'(n), 16'h0001);
    over_current <= 1'b0;
    over_voltage <= 1'b0;
    cyc(6);
    chk({13'h0, oc_fault_ff, ov_fault_ff, phase_enable_ff}, 16'h0006);
    step(1'b1);
    chk(position_ff, 16'h0000);
    rst_n <= 1'b0;
    enable_in <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(600);
    chk({14'h0, oc_fault_ff, ov_fault_ff}, 16'h0000);
    step(1'b1);
    chk(position_ff, 16'h0000);
    chk(16'(te_count), 16'h0000);
    tally_and_finish();
  end
  initial begin
    cyc(100000);
    bad_count++;
    tally_and_finish();
  end
endmodule // step_dir_input_fault_monitor_bench
